//--- include/chan_regs.svh
// Register indices, fields, reset values and counts of one channel
// Operation
// - Bit rate comes from a 16-bit counter loaded from both divisor bytes.
// - Divisor bytes replace indices 0 and 1 only while line control bit 7.
// - Enable bits mask the six sources; unmasked ones reach status and summary.
// - FIFO receive interrupt holds while level is at or above trigger.
// - Data ready sets when a character enters the FIFO, clears when empty.
// - FIFO on with enable bits 0-3 clear means polled mode.
// - Line status bit 1 flags a receive overrun.
// - Bits 2-4 give parity, framing, break of the head character.
// - Bit 5 holding empty; bit 6 also needs shift register empty.
// - Bit 7 flags an error in any character held in the FIFO.
// - Receive interrupt: one character without FIFO, trigger level with it.
// - Below trigger, not empty, idle 4 chars plus 12 bits gives timeout.
// - Receive interrupt enable resets to zero.
// - Enhanced bits change only while enhanced function bit 4 is one.
// - General outputs stay internal, looped to modem inputs in loopback.
// - Reading line status clears its interrupt; modem status likewise.
// - Timeout interrupt clears only once the receive FIFO is empty.
`ifndef CHAN_REGS_SVH
`define CHAN_REGS_SVH
`define IDX_HOLD      5'h00
`define IDX_IER       5'h01
`define IDX_ISR       5'h02
`define IDX_LCR       5'h03
`define IDX_MCR       5'h04
`define IDX_LSR       5'h05
`define IDX_MSR       5'h06
`define IDX_SPR       5'h07
`define IDX_FEATURE_CONTROL      5'h08
`define IDX_EFR       5'h09
`define IDX_TXLVL     5'h0a
`define IDX_RXLVL     5'h0b
`define IDX_XCHAR     5'h0c
`define IDX_STOP_CHAR_TWO     5'h0d
`define IDX_RESUME_CHAR_ONE      5'h0e
`define IDX_RESUME_CHAR_TWO      5'h0f
`define IDX_EVT_STAT  5'h10
`define IDX_EVT_CLR   5'h11
`define IDX_EVT_EN    5'h12
`define LCR_DIV_EN    7
`define EFR_ENH       4
`define MCR_LOOP      4
`define IER_ENH_MASK  8'he0
`define FCR_ENH_MASK  8'h30
`define MCR_ENH_MASK  8'he4
`define DLY_MASK      8'hf0
`define DIV_RESET     16'h0001
`define REG_RESET     8'h00
`define TRG_RESET     8'h01
`define TO_CHARS      4
`define TO_BITS       12
`define OVERSAMPLE    16
`define ISR_NONE      6'h01
`define ISR_LINE      6'h06
`define ISR_RECEIVE_READY_INTERRUPT     6'h04
`define ISR_TIMEOUT   6'h0c
`define ISR_TXRDY     6'h02
`define ISR_MODEM     6'h00
`define ISR_XCHAR     6'h10
`endif

//--- include/chan_pkg.sv
// Types shared by the channel register set
package chan_pkg;
    typedef struct packed {
        logic       brk;
        logic       framing;
        logic       parity;
        logic [7:0] data;
    } rx_char_t;
    typedef struct packed {
        logic       cd;
        logic       ri;
        logic       dsr;
        logic       cts;
    } modem_t;
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b01,
        BUS_WDATA = 2'b10
    } bus_state_t;
endpackage : chan_pkg

//--- hdl/char_fifo.sv
// Character FIFO with adjustable capacity limit
`timescale 1ns/10ps
module char_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 32,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             flush,
    input  wire logic [CW-1:0]    limit,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic      [CW-1:0]    count,
    output logic                  full
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic             do_push;
    logic             do_pop;

    // Pointers wrap naturally only for a power of two
    if (DEPTH < 2 || (1 << PW) != DEPTH)
        $error("char_fifo: DEPTH must be a power of two, 2 or more");

    assign full    = (count >= limit);
    assign do_push = push && !full;
    assign do_pop  = pop && (count != '0);
    assign head    = mem[rd_ptr];

    always_ff @(posedge hclk)
    begin
        if (do_push)
            mem[wr_ptr] <= push_data;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= wr_ptr + PW'(1);
            if (do_pop)
                rd_ptr <= rd_ptr + PW'(1);
            count <= count + CW'(do_push) - CW'(do_pop);
        end
    end
endmodule : char_fifo

//--- hdl/uart_channel.sv
// Channel register set behind an AHB-Lite slave
`timescale 1ns/10ps
`include "chan_regs.svh"
module uart_channel #(
    parameter int DEPTH = 32
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             rx_char_valid,
    input  wire chan_pkg::rx_char_t rx_char,
    input  wire logic             rx_line_busy,
    output logic      [7:0]       tx_data,
    output logic                  tx_valid,
    input  wire logic             tx_ready,
    input  wire logic             tx_shift_empty,
    input  wire chan_pkg::modem_t modem_in,
    output logic                  rts_n,
    output logic                  dtr_n,
    output logic                  bit_rate_tick,
    output logic                  polled_mode,
    output logic                  device_channel_interrupt_summary,
    output logic                  irq
);
    localparam int CW = $clog2(DEPTH + 1);
    if (DEPTH > 255)
        $error("uart_channel: level registers hold at most 255");

    chan_pkg::bus_state_t bus_state;
    logic [4:0]  wr_idx;
    logic [15:0] div;
    logic [15:0] div_cnt;
    logic [7:0]  interrupt_enable, line_control_register, modem_control, scratch_pad, feature_control, enhanced_function, dly, tx_fifo_trigger, rx_fifo_trigger;
    logic [7:0]  stop_char_one, stop_char_two, resume_char_one, resume_char_two;
    logic        fifo_en;
    logic [1:0]  fcr_mode;
    logic        overrun, line_int, tx_int, xoff_int, timeout_flag;
    logic        xon_det, xoff_det, tx_empty_q, avail_q;
    logic [3:0]  delta;
    logic [3:0]  modem_q;
    logic [CW-1:0] err_cnt;
    logic [9:0]  idle_cnt;
    logic [5:0]  evt_stat, evt_en, evt_set;
    logic        wr_pend, req, read_take;
    logic [4:0]  rd_idx;
    logic [7:0]  wd, rd_val, line_status;
    logic [5:0]  isr_code;
    logic        rx_flush, tx_flush, enh, divmap;
    logic        rx_pop, tx_push, rx_full, tx_full, rx_acc, rx_avail;
    logic [CW-1:0] rx_count, tx_count, limit, trig;
    chan_pkg::rx_char_t rx_head;
    logic [7:0]  tx_head;
    logic [3:0]  modem_eff;
    logic        src_line, src_rx, src_to, src_tx, src_modem, src_x;

    // Old bits stay where mask is set and enhanced access is closed
    function automatic logic [7:0] guarded(input logic [7:0] old_v,
        input logic [7:0] new_v, input logic [7:0] mask, input logic en);
        guarded = en ? new_v : ((old_v & mask) | (new_v & ~mask));
    endfunction : guarded

    function automatic logic [9:0] timeout_ticks(input logic [7:0] lc);
        logic [9:0] bits;
        bits = 10'd7 + 10'(lc[1:0]) + 10'(lc[3]) + 10'(lc[2]);
        timeout_ticks = 10'((`TO_CHARS * bits + `TO_BITS) * `OVERSAMPLE);
    endfunction : timeout_ticks

    assign enh    = enhanced_function[`EFR_ENH];
    assign divmap = line_control_register[`LCR_DIV_EN];
    assign wd     = hwdata[7:0];
    assign hresp  = 1'b0;
    assign req    = hsel && htrans[1] && hready;
    assign rd_idx = haddr[6:2];
    assign wr_pend = (bus_state == chan_pkg::BUS_WDATA);
    // A read behind a write waits one cycle so it sees the written value
    assign hreadyout = !(wr_pend && hsel && htrans[1] && !hwrite);
    assign read_take = req && !hwrite && hreadyout;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state <= chan_pkg::BUS_IDLE;
            wr_idx    <= 5'h00;
        end
        else
        begin
            case (bus_state)
                chan_pkg::BUS_IDLE,
                chan_pkg::BUS_WDATA:
                begin
                    if (req && hwrite && hreadyout)
                    begin
                        bus_state <= chan_pkg::BUS_WDATA;
                        wr_idx    <= haddr[6:2];
                    end
                    else
                        bus_state <= chan_pkg::BUS_IDLE;
                end
                default: bus_state <= chan_pkg::BUS_IDLE;
            endcase
        end
    end

    function automatic logic wr_to(input logic [4:0] i);
        wr_to = wr_pend && (wr_idx == i);
    endfunction : wr_to

    function automatic logic rd_of(input logic [4:0] i);
        rd_of = read_take && (rd_idx == i);
    endfunction : rd_of

    // Plain control registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div  <= `DIV_RESET;
            interrupt_enable  <= `REG_RESET;
            line_control_register  <= `REG_RESET;
            modem_control  <= `REG_RESET;
            scratch_pad  <= `REG_RESET;
            feature_control <= `REG_RESET;
            enhanced_function  <= `REG_RESET;
            dly  <= `REG_RESET;
            tx_fifo_trigger <= `TRG_RESET;
            rx_fifo_trigger <= `TRG_RESET;
            stop_char_one <= `REG_RESET;
            stop_char_two <= `REG_RESET;
            resume_char_one  <= `REG_RESET;
            resume_char_two  <= `REG_RESET;
            fifo_en  <= 1'b0;
            fcr_mode <= 2'b00;
            evt_en   <= 6'h00;
        end
        else if (wr_pend)
        begin
            case (wr_idx)
                `IDX_HOLD: if (divmap) div[7:0] <= wd;
                `IDX_IER:
                    if (divmap)
                        div[15:8] <= wd;
                    else
                        interrupt_enable <= guarded(interrupt_enable, wd, `IER_ENH_MASK, enh)
                            & 8'hef;
                `IDX_ISR:
                begin
                    fifo_en <= wd[0];
                    if (wd[0])
                        fcr_mode <= 2'(guarded({2'b00, fcr_mode, 4'h0},
                            wd, `FCR_ENH_MASK, enh) >> 4);
                end
                `IDX_LCR:   line_control_register <= wd;
                `IDX_MCR:   modem_control <= guarded(modem_control, wd, `MCR_ENH_MASK, enh);
                `IDX_MSR:   dly <= guarded(dly, wd, `DLY_MASK, enh)
                                & `DLY_MASK;
                `IDX_SPR:   scratch_pad <= wd;
                `IDX_FEATURE_CONTROL:  feature_control <= wd;
                `IDX_EFR:   enhanced_function <= wd;
                `IDX_TXLVL: tx_fifo_trigger <= wd;
                `IDX_RXLVL: rx_fifo_trigger <= wd;
                `IDX_XCHAR: stop_char_one <= wd;
                `IDX_STOP_CHAR_TWO: stop_char_two <= wd;
                `IDX_RESUME_CHAR_ONE:  resume_char_one <= wd;
                `IDX_RESUME_CHAR_TWO:  resume_char_two <= wd;
                `IDX_EVT_EN: evt_en <= wd[5:0];
                default: ;
            endcase
        end
    end

    // Bit rate counter, reloaded from the divisor; zero stops it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt       <= 16'h0000;
            bit_rate_tick <= 1'b0;
        end
        else
        begin
            bit_rate_tick <= (div != 16'h0000) && (div_cnt <= 16'h0001);
            if (div_cnt <= 16'h0001)
                div_cnt <= div;
            else
                div_cnt <= div_cnt - 16'h0001;
        end
    end

    // FIFOs; without FIFO mode the receiver holds a single character
    assign rx_flush = wr_to(`IDX_ISR) && wd[0] && wd[1];
    assign tx_flush = wr_to(`IDX_ISR) && wd[0] && wd[2];
    assign limit = fifo_en ? CW'(DEPTH) : CW'(1);
    assign trig  = (!fifo_en || rx_fifo_trigger == 8'h00) ? CW'(1) : CW'(rx_fifo_trigger);
    assign rx_pop  = rd_of(`IDX_HOLD) && !divmap;
    assign tx_push = wr_to(`IDX_HOLD) && !divmap;
    assign rx_acc  = rx_char_valid && !rx_full;
    assign rx_avail = (rx_count >= trig);

    char_fifo #(.WIDTH(11), .DEPTH(DEPTH), .CW(CW)) u_rx (
        .hclk(hclk), .hresetn(hresetn), .flush(rx_flush), .limit(limit),
        .push(rx_char_valid), .push_data(rx_char), .pop(rx_pop),
        .head(rx_head), .count(rx_count), .full(rx_full));

    char_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx (
        .hclk(hclk), .hresetn(hresetn), .flush(tx_flush), .limit(limit),
        .push(tx_push), .push_data(wd), .pop(tx_ready && tx_valid),
        .head(tx_head), .count(tx_count), .full(tx_full));

    assign tx_data  = tx_head;
    assign tx_valid = (tx_count != '0);

    // Errors held anywhere in the FIFO are counted, not scanned
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            err_cnt <= '0;
        else if (rx_flush)
            err_cnt <= '0;
        else
            err_cnt <= err_cnt
                + CW'(rx_acc && (|rx_char[10:8]))
                - CW'(rx_pop && rx_count != '0 && (|rx_head[10:8]));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            overrun <= 1'b0;
        else if (rx_char_valid && rx_full)
            overrun <= 1'b1;
        else if (rd_of(`IDX_LSR))
            overrun <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            line_int <= 1'b0;
        else if ((rx_char_valid && rx_full) || (rx_acc && |rx_char[10:8]))
            line_int <= 1'b1;
        else if (rd_of(`IDX_LSR))
            line_int <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_empty_q <= 1'b1;
            tx_int     <= 1'b0;
        end
        else
        begin
            tx_empty_q <= (tx_count == '0);
            if (tx_count == '0 && !tx_empty_q)
                tx_int <= 1'b1;
            else if (rd_of(`IDX_ISR) || tx_push)
                tx_int <= 1'b0;
        end
    end

    // Idle time in oversampled ticks; any activity restarts it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            idle_cnt     <= 10'h000;
            timeout_flag <= 1'b0;
        end
        else
        begin
            if (!fifo_en || rx_count == '0 || rx_avail || rx_line_busy
                || rx_char_valid || rx_pop)
                idle_cnt <= 10'h000;
            else if (bit_rate_tick && idle_cnt != timeout_ticks(line_control_register))
                idle_cnt <= idle_cnt + 10'h001;
            if (idle_cnt == timeout_ticks(line_control_register) && rx_count != '0)
                timeout_flag <= 1'b1;
            else if (rx_count == '0)
                timeout_flag <= 1'b0;
        end
    end

    // Modem inputs; general outputs only feed loopback
    assign modem_eff = modem_control[`MCR_LOOP] ? {modem_control[3], modem_control[2], modem_control[0], modem_control[1]}
                                      : modem_in;
    assign rts_n = modem_control[`MCR_LOOP] ? 1'b1 : ~modem_control[1];
    assign dtr_n = modem_control[`MCR_LOOP] ? 1'b1 : ~modem_control[0];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            modem_q <= 4'h0;
            delta   <= 4'h0;
        end
        else
        begin
            modem_q <= modem_eff;
            if (rd_of(`IDX_MSR))
                delta <= modem_eff ^ modem_q;
            else
                delta <= delta | (modem_eff ^ modem_q);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            xon_det  <= 1'b0;
            xoff_det <= 1'b0;
            xoff_int <= 1'b0;
        end
        else
        begin
            if (rx_acc && enhanced_function[3:0] != 4'h0
                && (rx_char.data == resume_char_one || rx_char.data == resume_char_two))
                xon_det <= 1'b1;
            else if (rd_of(`IDX_XCHAR))
                xon_det <= 1'b0;
            if (rx_acc && enhanced_function[3:0] != 4'h0
                && (rx_char.data == stop_char_one || rx_char.data == stop_char_two))
            begin
                xoff_det <= 1'b1;
                xoff_int <= 1'b1;
            end
            else
            begin
                if (rd_of(`IDX_XCHAR))
                    xoff_det <= 1'b0;
                if (rd_of(`IDX_ISR))
                    xoff_int <= 1'b0;
            end
        end
    end

    // Masked sources in priority order
    assign src_line  = interrupt_enable[2] && line_int;
    assign src_rx    = interrupt_enable[0] && rx_avail && rx_count != '0;
    assign src_to    = interrupt_enable[0] && timeout_flag;
    assign src_tx    = interrupt_enable[1] && tx_int;
    assign src_modem = interrupt_enable[3] && (delta != 4'h0);
    assign src_x     = enh && interrupt_enable[5] && xoff_int;

    always_comb
    begin
        if (src_line)       isr_code = `ISR_LINE;
        else if (src_rx)    isr_code = `ISR_RECEIVE_READY_INTERRUPT;
        else if (src_to)    isr_code = `ISR_TIMEOUT;
        else if (src_tx)    isr_code = `ISR_TXRDY;
        else if (src_modem) isr_code = `ISR_MODEM;
        else if (src_x)     isr_code = `ISR_XCHAR;
        else                isr_code = `ISR_NONE;
    end

    assign device_channel_interrupt_summary = (isr_code != `ISR_NONE);
    assign polled_mode = fifo_en && (interrupt_enable[3:0] == 4'h0);

    assign line_status = {err_cnt != '0,
                  tx_count == '0 && tx_shift_empty,
                  tx_count == '0,
                  rx_count != '0 ? rx_head[10:8] : 3'b000,
                  overrun,
                  rx_count != '0};

    // Sticky event record behind its own enable mask
    assign evt_set = {xon_det | xoff_det, delta != 4'h0, tx_int,
                      line_int, timeout_flag, rx_avail && !avail_q};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            evt_stat <= 6'h00;
            avail_q  <= 1'b0;
        end
        else
        begin
            avail_q  <= rx_avail && rx_count != '0;
            evt_stat <= evt_set | (evt_stat
                & ~(wr_to(`IDX_EVT_CLR) ? wd[5:0] : 6'h00));
        end
    end

    assign irq = |(evt_stat & evt_en);

    always_comb
    begin
        case (rd_idx)
            `IDX_HOLD:  rd_val = divmap ? div[7:0] : rx_head[7:0];
            `IDX_IER:   rd_val = divmap ? div[15:8] : interrupt_enable;
            `IDX_ISR:   rd_val = {{2{fifo_en}}, enh ? isr_code[5:4] : 2'b00,
                                  isr_code[3:0]};
            `IDX_LCR:   rd_val = line_control_register;
            `IDX_MCR:   rd_val = modem_control;
            `IDX_LSR:   rd_val = line_status;
            `IDX_MSR:   rd_val = {modem_eff, delta};
            `IDX_SPR:   rd_val = scratch_pad;
            `IDX_FEATURE_CONTROL:  rd_val = feature_control;
            `IDX_EFR:   rd_val = enhanced_function;
            `IDX_TXLVL: rd_val = 8'(tx_count);
            `IDX_RXLVL: rd_val = 8'(rx_count);
            `IDX_XCHAR: rd_val = {6'h00, xon_det, xoff_det};
            `IDX_EVT_STAT: rd_val = {2'b00, evt_stat};
            `IDX_EVT_EN:   rd_val = {2'b00, evt_en};
            default:    rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (read_take)
            hrdata <= {24'h000000, rd_val};
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    div_map_a: assert property (rd_of(`IDX_HOLD) && divmap
        |=> hrdata[7:0] == $past(div[7:0]))
        else $error("divisor low byte not returned");
    rx_trig_a: assert property (fifo_en && interrupt_enable[0] && !src_line
        && rx_count >= trig && rx_count != '0 |-> isr_code == `ISR_RECEIVE_READY_INTERRUPT)
        else $error("receive trigger not reported");
    ready_bit_a: assert property (rx_acc && !rx_flush
        |=> line_status[0])
        else $error("data ready not set");
    overrun_set_a: assert property (rx_char_valid && rx_full
        |=> overrun [*1] ##1 overrun || $past(rd_of(`IDX_LSR)))
        else $error("overrun flag lost");
    shift_empty_a: assert property (line_status[6] |-> line_status[5])
        else $error("shift empty without holding empty");
    rx_enable_a: assert property ($rose(hresetn) |-> interrupt_enable == 8'h00)
        else $error("enable register not cleared by reset");
    enh_lock_a: assert property (wr_to(`IDX_IER) && !divmap
        && !enh |=> interrupt_enable[7:5] == $past(interrupt_enable[7:5]))
        else $error("enhanced enable bits changed while locked");
    lsr_clear_a: assert property (rd_of(`IDX_LSR) && !rx_char_valid
        |=> !line_int && !overrun)
        else $error("line status read did not clear");
    timeout_hold_a: assert property (timeout_flag && rx_count != '0
        |=> timeout_flag)
        else $error("timeout cleared before FIFO empty");
    xchar_clear_a: assert property (rd_of(`IDX_XCHAR) && !rx_acc
        |=> !xon_det && !xoff_det)
        else $error("flow character flags not cleared");
    polled_a: assert property (fifo_en && interrupt_enable[3:0] == 4'h0
        |-> polled_mode && !device_channel_interrupt_summary || src_x)
        else $error("polled mode raised an interrupt");

    rx_int_c: cover property (src_rx ##[1:50] !src_rx);
    timeout_c: cover property ($rose(timeout_flag));
    overrun_c: cover property ($rose(overrun));
    stall_c: cover property (!hreadyout);
endmodule : uart_channel

//--- verif/far_side.sv
// Remote serial side of one channel: receive shifter and transmit shifter
`timescale 1ns/10ps
module far_side (
    input  wire logic          hclk,
    input  wire logic          tx_valid,
    output logic               rx_char_valid,
    output chan_pkg::rx_char_t rx_char,
    output logic               rx_line_busy,
    output logic               tx_ready,
    output logic               tx_shift_empty
);
    initial
    begin
        rx_char_valid = 1'b0;
        rx_char = '0;
        tx_ready = 1'b0;
    end
    assign rx_line_busy = rx_char_valid;
    assign tx_shift_empty = ~tx_valid;
    // Slow shifter: takes a character only every other cycle
    always @(posedge hclk)
        tx_ready <= tx_valid & ~tx_ready;
    task send(input chan_pkg::rx_char_t c);
        @(posedge hclk);
        rx_char_valid <= 1'b1;
        rx_char <= c;
        @(posedge hclk);
        rx_char_valid <= 1'b0;
        // Stale data scrambled so nothing can lean on it
        rx_char <= ~c;
    endtask : send
endmodule : far_side

//--- verif/uart_channel_tb_top.sv
// Self-checking bench for the channel register set
`timescale 1ns/10ps
module uart_channel_tb_top;
    logic               hclk = 1'b0;
    logic               hresetn = 1'b0;
    logic [31:0]        haddr = '0;
    logic [1:0]         htrans = '0;
    logic               hwrite = 1'b0;
    logic [31:0]        hwdata = '0;
    logic [31:0]        hrdata;
    logic               hreadyout, hresp, rx_char_valid, rx_line_busy;
    chan_pkg::rx_char_t rx_char;
    logic [7:0]         tx_data;
    logic               tx_valid, tx_ready, tx_shift_empty;
    chan_pkg::modem_t   modem_in = '0;
    logic               rts_n, dtr_n, bit_rate_tick, polled_mode, irq;
    logic               device_channel_interrupt_summary;
    int                 n_errors = 0;
    int                 check_count = 0;
    int                 ticks = 0;
    int                 w = 0;
    logic [7:0]         q;
    always #2 hclk = ~hclk;
    always @(posedge hclk)
        if (bit_rate_tick === 1'b1)
            ticks++;
    uart_channel uart_channel_inst (.hclk, .hresetn, .hsel(1'b1), .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata,
        .hrdata, .hreadyout, .hresp, .rx_char_valid, .rx_char,
        .rx_line_busy, .tx_data, .tx_valid, .tx_ready, .tx_shift_empty,
        .modem_in, .rts_n, .dtr_n, .bit_rate_tick, .polled_mode,
        .device_channel_interrupt_summary, .irq);
    far_side far_side_inst (.hclk, .tx_valid, .rx_char_valid, .rx_char,
        .rx_line_busy, .tx_ready, .tx_shift_empty);
    task stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task chk(input logic [7:0] s, input logic [7:0] e);
        #1;
        check_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task waitr;
        int k;
        for (k = 0; k < 20; k++)
        begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                break;
        end
        if (k == 20)
        begin
            n_errors++;
            stop_test;
        end
    endtask : waitr
    task xfer(input logic w, input logic [4:0] i, input logic [7:0] d);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr <= {25'h0, i, 2'h0};
        hwrite <= w;
        waitr();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        waitr();
        q = hrdata[7:0];
    endtask : xfer
    task rd(input logic [4:0] i, input logic [7:0] e);
        xfer(1'b0, i, 8'h00);
        chk(q, e);
    endtask : rd
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd(5'h01, 8'h00);
        rd(5'h05, 8'h60);
        rd(5'h0c, 8'h00);
        xfer(1'b1, 5'h03, 8'h80);
        xfer(1'b1, 5'h00, 8'h05);
        xfer(1'b1, 5'h01, 8'h12);
        rd(5'h00, 8'h05);
        rd(5'h01, 8'h12);
        xfer(1'b1, 5'h01, 8'h00);
        // Counter may still run out the old divisor: skip two ticks first
        #1 ticks = 0;
        for (w = 0; w < 10000 && ticks < 2; w++)
        begin
            @(posedge hclk);
            #1;
        end
        if (w == 10000)
        begin
            n_errors++;
            stop_test;
        end
        ticks = 0;
        repeat (50) @(posedge hclk);
        #1 chk(ticks[7:0], 8'h0a);
        xfer(1'b1, 5'h03, 8'h00);
        rd(5'h01, 8'h00);
        far_side_inst.send({1'b0, 1'b0, 1'b1, 8'h5a});
        rd(5'h05, 8'he5);
        far_side_inst.send(11'h0a5);
        rd(5'h05, 8'he7);
        rd(5'h00, 8'h5a);
        rd(5'h05, 8'h60);
        xfer(1'b1, 5'h01, 8'he0);
        rd(5'h01, 8'h00);
        xfer(1'b1, 5'h09, 8'h10);
        xfer(1'b1, 5'h01, 8'he0);
        rd(5'h01, 8'he0);
        xfer(1'b1, 5'h01, 8'h00);
        xfer(1'b1, 5'h02, 8'h01);
        #1 chk({7'h0, polled_mode}, 8'h01);
        xfer(1'b1, 5'h01, 8'h01);
        #1 chk({7'h0, polled_mode}, 8'h00);
        xfer(1'b1, 5'h12, 8'h01);
        far_side_inst.send(11'h033);
        rd(5'h02, 8'hc4);
        chk({7'h0, device_channel_interrupt_summary}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        xfer(1'b1, 5'h12, 8'h00);
        #1 chk({7'h0, irq}, 8'h00);
        xfer(1'b1, 5'h11, 8'h01);
        rd(5'h10, 8'h04);
        rd(5'h00, 8'h33);
        rd(5'h02, 8'hc1);
        xfer(1'b1, 5'h00, 8'h3c);
        #1 chk(tx_data, 8'h3c);
        chk({7'h0, tx_valid}, 8'h01);
        xfer(1'b1, 5'h04, 8'h1f);
        #1 chk({6'h0, rts_n, dtr_n}, 8'h03);
        rd(5'h06, 8'hff);
        rd(5'h06, 8'hf0);
        stop_test;
    end
endmodule : uart_channel_tb_top
